// File: ivc_arb.sv
// ivc_arb: picks the pending source with the highest priority field
// assumes the source table is in ascending vector order
`timescale 1ns/1ps
module ivc_arb
  import ivc_pkg::*;
(
  ivc_arb_if.arb a
);
  // strictly greater keeps the lower index, so the lower vector, on a tie
  always_comb begin
    a.win_valid = 1'b0;
    a.win_idx   = '0;
    a.win_level = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (a.pend[i] && (!a.win_valid || a.prio[i] > a.win_level)) begin
        a.win_valid = 1'b1;
        a.win_idx   = IW'(i);
        a.win_level = a.prio[i];
      end
    end
  end
endmodule

// File: ivc_arb_if.sv
// ivc_arb_if: pending sources and priorities to the arbiter, winner back
// assumes purely combinational use within one clock domain
`timescale 1ns/1ps
interface ivc_arb_if;
  import ivc_pkg::*;
  logic [NSRC-1:0] pend;
  logic [2:0]      prio [NSRC];
  logic            win_valid;
  logic [IW-1:0]   win_idx;
  logic [2:0]      win_level;
  modport ctl (output pend, prio, input win_valid, win_idx, win_level);
  modport arb (input pend, prio, output win_valid, win_idx, win_level);
endinterface

// File: ivc_far_end.sv
// ivc_far_end: event sources and processor core facing the vector control
// assumes the bench calls its tasks and sets ack_en, ack_dly and hold_instr
`timescale 1ns/1ps
module ivc_far_end
  import ivc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            irq_req,
  output logic      [NEXT-1:0] ext_pin,
  output logic      [NPER-1:0] periph_evt,
  output logic                 hold_instr,
  output logic                 irq_ack
);
  logic       ack_en;
  int         ack_dly;
  logic [3:0] wait_cnt;

  // quiet sources, core not yet acknowledging
  initial begin
    ext_pin    = '0;
    periph_evt = '0;
    hold_instr = 1'b0;
    ack_en     = 1'b0;
    ack_dly    = 2;
  end

  // core takes a presented request after ack_dly cycles, one pulse each
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_ack) begin
      irq_ack  <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (irq_req && ack_en) begin
      if (int'(wait_cnt) + 1 >= ack_dly) irq_ack <= 1'b1;
      else wait_cnt <= wait_cnt + 4'h1;
    end else begin
      wait_cnt <= 4'h0;
    end
  end

  // level change on one external pin
  task automatic set_pin(input int k, input logic v);
    @(posedge clk);
    ext_pin[k] <= v;
  endtask

  // single-cycle peripheral event
  task automatic pulse_evt(input int b);
    @(posedge clk);
    periph_evt[b] <= 1'b1;
    @(posedge clk);
    periph_evt[b] <= 1'b0;
  endtask
endmodule

// File: ivc_pkg.sv
// ivc_pkg: constants, source table and register map of the vector control
// assumes one clock domain and a word-indexed register port
package ivc_pkg;
  localparam int NSRC = 15;
  localparam int NEXT = 5;
  localparam int NPER = 10;
  localparam int AW   = 8;
  localparam int DW   = 16;
  localparam int IW   = 4;

  // register indexes
  localparam logic [AW-1:0] A_FLAG0     = 8'h00; // flag words 0..7
  localparam logic [AW-1:0] A_EN0       = 8'h08; // enable words 0..7
  localparam logic [AW-1:0] A_PRIO0     = 8'h10; // priority words 0..29
  localparam logic [AW-1:0] A_PRIO_LAST = 8'h2d;
  localparam logic [AW-1:0] A_CTL2      = 8'h30;
  localparam logic [AW-1:0] A_EVT_STS   = 8'h31;
  localparam logic [AW-1:0] A_EVT_MASK  = 8'h32;
  localparam logic [AW-1:0] A_ACTIVE    = 8'h33;

  // control word 2 fields
  localparam int B_GIE  = 15;
  localparam int B_HOLD = 14;
  localparam int B_TRAP = 13;
  localparam int B_ALT  = 8;
  localparam logic [DW-1:0] CTL2_RST = 16'h0000;

  // event status bits
  localparam int E_TRAP = 0;
  localparam int E_REQ  = 1;
  localparam int NEVT   = 2;

  typedef struct packed {
    logic [6:0]  vec;
    logic [6:0]  irq;
    logic [23:0] addr;
    logic [2:0]  fw;
    logic [3:0]  fb;
    logic [4:0]  pw;
    logic [3:0]  pl;
  } ivc_src_s;

  // sources in ascending vector order: vec, irq, addr, flag word, bit, prio word, lsb
  localparam ivc_src_s SRC_TAB [NSRC] = '{
    '{7'h08, 7'h00, 24'h000014, 3'h0, 4'h0, 5'h00, 4'h0},
    '{7'h09, 7'h01, 24'h000016, 3'h0, 4'h1, 5'h00, 4'h4},
    '{7'h0c, 7'h04, 24'h00001c, 3'h0, 4'h4, 5'h01, 4'h0},
    '{7'h15, 7'h0d, 24'h00002e, 3'h0, 4'hd, 5'h03, 4'h4},
    '{7'h17, 7'h0f, 24'h000032, 3'h0, 4'hf, 5'h03, 4'hc},
    '{7'h1b, 7'h13, 24'h00003a, 3'h1, 4'h3, 5'h04, 4'hc},
    '{7'h1c, 7'h14, 24'h00003c, 3'h1, 4'h4, 5'h05, 4'h0},
    '{7'h25, 7'h1d, 24'h00004e, 3'h1, 4'hd, 5'h07, 4'h4},
    '{7'h3d, 7'h35, 24'h00007e, 3'h3, 4'h5, 5'h0d, 4'h4},
    '{7'h3e, 7'h36, 24'h000080, 3'h3, 4'h6, 5'h0d, 4'h8},
    '{7'h3f, 7'h37, 24'h000082, 3'h3, 4'h7, 5'h0d, 4'hc},
    '{7'h5c, 7'h54, 24'h0000bc, 3'h5, 4'h4, 5'h15, 4'h0},
    '{7'h6b, 7'h63, 24'h0000da, 3'h6, 4'h3, 5'h18, 4'hc},
    '{7'h72, 7'h6a, 24'h0000e8, 3'h6, 4'ha, 5'h1a, 4'h8},
    '{7'h7d, 7'h75, 24'h0000fe, 3'h7, 4'h5, 5'h1d, 4'h4}
  };
endpackage

// File: ivc_top.sv
// ivc_top: interrupt vector control, register port, edge detect, request out
// assumes all inputs synchronous to CLK_SYS and a master that never waits
`timescale 1ns/1ps
module ivc_top
  import ivc_pkg::*;
#(
  parameter logic [23:0] ALT_OFS = 24'h000100
) (
  input  wire logic            CLK_SYS,
  input  wire logic            ARST_N,
  input  wire logic [AW-1:0]   ADDR,
  input  wire logic [DW-1:0]   WDATA,
  input  wire logic            WR_STB,
  input  wire logic            RD_STB,
  output logic      [DW-1:0]   RDATA,
  input  wire logic [NEXT-1:0] EXT_PIN,
  input  wire logic [NPER-1:0] PERIPH_EVT,
  input  wire logic            HOLD_INSTR,
  input  wire logic            IRQ_ACK,
  output logic                 IRQ_REQ,
  output logic      [6:0]      IRQ_VECTOR,
  output logic      [6:0]      IRQ_NUM,
  output logic      [23:0]     IRQ_ADDR,
  output logic      [2:0]      IRQ_LEVEL,
  output logic                 SOFT_TRAP,
  output logic                 INT_OUT
);

  // block state
  logic [NSRC-1:0] flag;
  logic [NSRC-1:0] en;
  logic [2:0]      prio [NSRC];
  logic            global_irq_enable;
  logic            hold_sts;
  logic            alt;
  logic [NEXT-1:0] pol;
  logic [NEXT-1:0] ext_prev;
  logic            primed;
  logic [NEVT-1:0] evt_sts;
  logic [NEVT-1:0] evt_mask;
  logic [IW-1:0]   cur_idx;

  // combinational helpers
  logic [NSRC-1:0] next_flag;
  logic [NSRC-1:0] src_evt;
  logic [NSRC-1:0] ack_clr;
  logic [NEXT-1:0] ext_edge;
  logic [NEVT-1:0] evt_set;
  logic [NEVT-1:0] next_sts;
  logic [NEVT-1:0] next_mask;
  logic [DW-1:0]   next_rdata;
  logic [DW-1:0]   ctl2_rd;
  logic [4:0]      prio_word;
  logic            prio_hit;
  logic            wr_flag;
  logic            wr_en;
  logic            wr_prio;
  logic            wr_ctl;
  logic            next_req;

  ivc_arb_if arb_bus ();

  ivc_arb u_arb (
    .a (arb_bus.arb)
  );

  // true when the address falls in an eight-word bank
  function automatic logic in_bank(input logic [AW-1:0] adr, input logic [AW-1:0] base);
    return adr[AW-1:3] == base[AW-1:3];
  endfunction

  // gathers per-source bits into the layout of one flag or enable word
  function automatic logic [DW-1:0] pack_word(input logic [NSRC-1:0] v, input logic [2:0] w);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (SRC_TAB[i].fw == w) begin
        r[SRC_TAB[i].fb] = v[i];
      end
    end
    return r;
  endfunction

  // address decode
  assign prio_hit  = (ADDR >= A_PRIO0) && (ADDR <= A_PRIO_LAST);
  assign prio_word = 5'(ADDR - A_PRIO0);
  assign wr_flag   = WR_STB && in_bank(ADDR, A_FLAG0);
  assign wr_en     = WR_STB && in_bank(ADDR, A_EN0);
  assign wr_prio   = WR_STB && prio_hit;
  assign wr_ctl    = WR_STB && (ADDR == A_CTL2);

  // edge detect per external input, polarity chosen by software
  genvar g;
  generate
    for (g = 0; g < NEXT; g++) begin : g_edge
      assign ext_edge[g] = primed && (pol[g] ? (ext_prev[g] && !EXT_PIN[g])
                                             : (!ext_prev[g] && EXT_PIN[g]));
    end
  endgenerate

  // previous pin level; first cycle after reset sees no edge
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_prev <= '0;
      primed   <= 1'b0;
    end else begin
      ext_prev <= EXT_PIN;
      primed   <= 1'b1;
    end
  end

  // event vector in table order
  assign src_evt = {PERIPH_EVT[9:5], ext_edge[4:1], PERIPH_EVT[4:0], ext_edge[0]};

  // core acknowledge retires the presented source
  always_comb begin
    ack_clr = '0;
    if (IRQ_ACK && IRQ_REQ) begin
      ack_clr[cur_idx] = 1'b1;
    end
  end

  // flag update: write or acknowledge, then a new event wins
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      next_flag[i] = flag[i];
      if (wr_flag && ADDR[2:0] == SRC_TAB[i].fw) begin
        next_flag[i] = WDATA[SRC_TAB[i].fb];
      end
      if (ack_clr[i]) begin
        next_flag[i] = 1'b0;
      end
      next_flag[i] = next_flag[i] | src_evt[i];
    end
  end

  // request flags
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end

  // enable bits
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      en <= '0;
    end else if (wr_en) begin
      for (int i = 0; i < NSRC; i++) begin
        if (ADDR[2:0] == SRC_TAB[i].fw) begin
          en[i] <= WDATA[SRC_TAB[i].fb];
        end
      end
    end
  end

  // priority fields
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < NSRC; i++) begin
        prio[i] <= '0;
      end
    end else if (wr_prio) begin
      for (int i = 0; i < NSRC; i++) begin
        if (prio_word == SRC_TAB[i].pw) begin
          prio[i] <= WDATA[SRC_TAB[i].pl +: 3];
        end
      end
    end
  end

  // control word 2, writable fields
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      global_irq_enable       <= CTL2_RST[B_GIE];
      SOFT_TRAP <= CTL2_RST[B_TRAP];
      alt       <= CTL2_RST[B_ALT];
      pol       <= CTL2_RST[NEXT-1:0];
    end else if (wr_ctl) begin
      global_irq_enable       <= WDATA[B_GIE];
      SOFT_TRAP <= WDATA[B_TRAP];
      alt       <= WDATA[B_ALT];
      pol       <= WDATA[NEXT-1:0];
    end
  end

  // hold-instruction status follows the core, never software
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_sts <= CTL2_RST[B_HOLD];
    end else begin
      hold_sts <= HOLD_INSTR;
    end
  end

  assign ctl2_rd = {global_irq_enable, hold_sts, SOFT_TRAP, 4'h0, alt, 3'h0, pol};

  // arbitration input; an acknowledged source drops out at once
  always_comb begin
    arb_bus.pend = flag & en & ~ack_clr;
    for (int i = 0; i < NSRC; i++) begin
      arb_bus.prio[i] = prio[i];
    end
  end

  // maskable requests need the global enable; traps bypass it
  assign next_req = global_irq_enable && arb_bus.win_valid;

  // presented request, vector and table address
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_REQ    <= 1'b0;
      cur_idx    <= '0;
      IRQ_VECTOR <= '0;
      IRQ_NUM    <= '0;
      IRQ_ADDR   <= '0;
      IRQ_LEVEL  <= '0;
    end else if (next_req) begin
      IRQ_REQ    <= 1'b1;
      cur_idx    <= arb_bus.win_idx;
      IRQ_VECTOR <= SRC_TAB[arb_bus.win_idx].vec;
      IRQ_NUM    <= SRC_TAB[arb_bus.win_idx].irq;
      IRQ_ADDR   <= SRC_TAB[arb_bus.win_idx].addr + (alt ? ALT_OFS : 24'h000000);
      IRQ_LEVEL  <= arb_bus.win_level;
    end else begin
      IRQ_REQ    <= 1'b0;
      cur_idx    <= '0;
      IRQ_VECTOR <= '0;
      IRQ_NUM    <= '0;
      IRQ_ADDR   <= '0;
      IRQ_LEVEL  <= '0;
    end
  end

  // block events: trap raised, new request presented
  always_comb begin
    evt_set         = '0;
    evt_set[E_TRAP] = wr_ctl && WDATA[B_TRAP] && !SOFT_TRAP;
    evt_set[E_REQ]  = next_req && !IRQ_REQ;
    next_sts        = evt_sts;
    if (WR_STB && ADDR == A_EVT_STS) begin
      next_sts = evt_sts & ~WDATA[NEVT-1:0];
    end
    next_sts  = next_sts | evt_set;
    next_mask = (WR_STB && ADDR == A_EVT_MASK) ? WDATA[NEVT-1:0] : evt_mask;
  end

  // sticky status, mask and level interrupt
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_sts  <= '0;
      evt_mask <= '0;
      INT_OUT  <= 1'b0;
    end else begin
      evt_sts  <= next_sts;
      evt_mask <= next_mask;
      INT_OUT  <= |(next_sts & next_mask);
    end
  end

  // read mux; unmapped indexes read zero
  always_comb begin
    next_rdata = '0;
    if (in_bank(ADDR, A_FLAG0)) begin
      next_rdata = pack_word(flag, ADDR[2:0]);
    end else if (in_bank(ADDR, A_EN0)) begin
      next_rdata = pack_word(en, ADDR[2:0]);
    end else if (prio_hit) begin
      for (int i = 0; i < NSRC; i++) begin
        if (prio_word == SRC_TAB[i].pw) begin
          next_rdata[SRC_TAB[i].pl +: 3] = prio[i];
        end
      end
    end else begin
      case (ADDR)
        A_CTL2:     next_rdata = ctl2_rd;
        A_EVT_STS:  next_rdata = {{(DW-NEVT){1'b0}}, evt_sts};
        A_EVT_MASK: next_rdata = {{(DW-NEVT){1'b0}}, evt_mask};
        A_ACTIVE:   next_rdata = {IRQ_REQ, IRQ_LEVEL, 5'h00, IRQ_VECTOR};
        default:    next_rdata = '0;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD_STB ? next_rdata : '0;
    end
  end

  // independent maximum of pending levels for checking
  logic [2:0]      chk_max;
  logic [2:0]      chk_max_q;
  logic [NSRC-1:0] pend_q;
  always_comb begin
    chk_max = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (arb_bus.pend[i] && prio[i] > chk_max) begin
        chk_max = prio[i];
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      chk_max_q <= '0;
      pend_q    <= '0;
    end else begin
      chk_max_q <= chk_max;
      pend_q    <= arb_bus.pend; // what the arbiter saw last cycle
    end
  end

  sequence s_rd_ctl;
    RD_STB && ADDR == A_CTL2;
  endsequence
  sequence s_trap_wr;
    WR_STB && ADDR == A_CTL2 && WDATA[B_TRAP];
  endsequence
  sequence s_rise0;
    !EXT_PIN[0] ##1 (EXT_PIN[0] && !pol[0] && primed);
  endsequence
  sequence s_fall0;
    EXT_PIN[0] ##1 (!EXT_PIN[0] && pol[0] && primed);
  endsequence

  property p_hold;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (HOLD_INSTR ##1 s_rd_ctl) |=> RDATA[B_HOLD];
  endproperty
  a_hold: assert property (p_hold) else $error("hold status not shown");

  property p_trap;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    s_trap_wr |=> SOFT_TRAP && (evt_sts[E_TRAP] || $past(SOFT_TRAP));
  endproperty
  a_trap: assert property (p_trap) else $error("trap not raised");

  property p_alt;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    IRQ_REQ |-> IRQ_ADDR == SRC_TAB[cur_idx].addr + ($past(alt) ? ALT_OFS : 24'h000000);
  endproperty
  a_alt: assert property (p_alt) else $error("wrong table address");

  property p_edge;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (s_rise0 or s_fall0) |=> flag[0];
  endproperty
  a_edge: assert property (p_edge) else $error("edge not flagged");

  property p_ext0;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    (global_irq_enable && flag[0] && en[0] && prio[0] == 3'h7 && !ack_clr[0])
      |=> IRQ_REQ && IRQ_VECTOR == 7'h08 && IRQ_NUM == 7'h00;
  endproperty
  a_ext0: assert property (p_ext0) else $error("input 0 not presented");

  property p_vec;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    IRQ_REQ |-> IRQ_VECTOR == SRC_TAB[cur_idx].vec && IRQ_NUM == SRC_TAB[cur_idx].irq
      && pend_q[cur_idx];
  endproperty
  a_vec: assert property (p_vec) else $error("vector mismatch");

  property p_gie;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    !global_irq_enable |=> !IRQ_REQ;
  endproperty
  a_gie: assert property (p_gie) else $error("request while disabled");

  property p_win;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    IRQ_REQ |-> IRQ_LEVEL == chk_max_q;
  endproperty
  a_win: assert property (p_win) else $error("not highest priority");

  property p_int;
    @(posedge CLK_SYS) disable iff (!ARST_N)
    ($rose(IRQ_REQ) && evt_mask[E_REQ]) |-> INT_OUT && evt_sts[E_REQ];
  endproperty
  a_int: assert property (p_int) else $error("interrupt level wrong");

endmodule

// File: tb.sv
// tb: self-checking bench for the interrupt vector control
// assumes ivc_pkg register map and the far-end model in ivc_far_end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb
  import ivc_pkg::*;
;
  localparam logic [23:0] ALT = 24'h000200;
  logic            clk;
  logic            arst_n;
  logic [AW-1:0]   addr;
  logic [DW-1:0]   wdata;
  logic            wr_stb;
  logic            rd_stb;
  logic [DW-1:0]   rdata;
  logic [NEXT-1:0] ext_pin;
  logic [NPER-1:0] periph_evt;
  logic            hold_instr;
  logic            irq_ack;
  logic            irq_req;
  logic [6:0]      irq_vector;
  logic [6:0]      irq_num;
  logic [23:0]     irq_addr;
  logic [2:0]      irq_level;
  logic            soft_trap;
  logic            int_out;
  logic [DW-1:0]   rv;
  int              fails;
  int              checks;
  // per source: vector, flag word, bit, priority word, lsb, trigger (16+k is pin k)
  int vec_t  [NSRC] = '{8, 9, 12, 21, 23, 27, 28, 37, 61, 62, 63, 92, 107, 114, 125};
  int fw_t   [NSRC] = '{0, 0, 0, 0, 0, 1, 1, 1, 3, 3, 3, 5, 6, 6, 7};
  int fb_t   [NSRC] = '{0, 1, 4, 13, 15, 3, 4, 13, 5, 6, 7, 4, 3, 10, 5};
  int pw_t   [NSRC] = '{0, 0, 1, 3, 3, 4, 5, 7, 13, 13, 13, 21, 24, 26, 29};
  int pl_t   [NSRC] = '{0, 4, 0, 4, 12, 12, 0, 4, 4, 8, 12, 0, 12, 8, 4};
  int trig_t [NSRC] = '{16, 0, 1, 2, 3, 4, 17, 18, 19, 20, 5, 6, 7, 8, 9};

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ivc_top #(.ALT_OFS(ALT)) dut_u (
    .CLK_SYS(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .EXT_PIN(ext_pin), .PERIPH_EVT(periph_evt), .HOLD_INSTR(hold_instr),
    .IRQ_ACK(irq_ack), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_NUM(irq_num),
    .IRQ_ADDR(irq_addr), .IRQ_LEVEL(irq_level), .SOFT_TRAP(soft_trap), .INT_OUT(int_out)
  );

  ivc_far_end far_u (
    .clk(clk), .arst_n(arst_n), .irq_req(irq_req), .ext_pin(ext_pin),
    .periph_evt(periph_evt), .hold_instr(hold_instr), .irq_ack(irq_ack)
  );

  // verdict and end of run
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // bounded wait for the request line to reach a level
  task automatic wait_req(input logic lvl);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      #1;
      if (irq_req === lvl) return;
    end
    fails++;
    $display("mismatch irq_req exp %0h got %0h", lvl, irq_req);
    end_sim();
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
  endtask

  // reset value, read-only hold bit, trap bit, unmapped index
  task automatic t_regs();
    rd(A_CTL2, rv);
    `CHK("ctl2 reset", CTL2_RST, rv)
    wr(A_CTL2, 16'hffff);
    rd(A_CTL2, rv);
    `CHK("ctl2 rw", 16'ha11f, rv)
    `CHK("soft trap", 1'b1, soft_trap)
    wr(8'h3f, 16'hffff);
    rd(8'h3f, rv);
    `CHK("unmapped", 16'h0000, rv)
    wr(A_CTL2, 16'h0000);
    cycles(2);
    `CHK("soft trap off", 1'b0, soft_trap)
    hold_instr_set(1'b1);
    rd(A_CTL2, rv);
    `CHK("hold on", 16'h4000, rv)
    hold_instr_set(1'b0);
    rd(A_CTL2, rv);
    `CHK("hold off", 16'h0000, rv)
  endtask

  task automatic hold_instr_set(input logic v);
    @(posedge clk);
    far_u.hold_instr <= v;
    cycles(2);
  endtask

  // every source once: vector, number, address, level, ack clears flag
  task automatic t_map();
    logic [2:0] p;
    far_u.ack_en = 1'b1;
    wr(A_CTL2, 16'h8000);
    for (int i = 0; i < NSRC; i++) begin
      p = 3'((i % 7) + 1);
      far_u.ack_dly = (i % 2) ? 2 : 6;
      wr(A_EN0 + 8'(fw_t[i]), 16'h0001 << fb_t[i]);
      wr(A_PRIO0 + 8'(pw_t[i]), {13'h0, p} << pl_t[i]);
      if (trig_t[i] >= 16) far_u.set_pin(trig_t[i] - 16, 1'b1);
      else far_u.pulse_evt(trig_t[i]);
      wait_req(1'b1);
      `CHK("vector", 7'(vec_t[i]), irq_vector)
      `CHK("number", 7'(vec_t[i] - 8), irq_num)
      `CHK("address", 24'(20 + 2 * (vec_t[i] - 8)), irq_addr)
      `CHK("level", p, irq_level)
      wait_req(1'b0);
      rd(A_FLAG0 + 8'(fw_t[i]), rv);
      `CHK("flag acked", 16'h0000, rv)
      wr(A_EN0 + 8'(fw_t[i]), 16'h0000);
      wr(A_PRIO0 + 8'(pw_t[i]), 16'h0000);
      if (trig_t[i] >= 16) far_u.set_pin(trig_t[i] - 16, 1'b0);
    end
  endtask

  // falling-edge polarity on each external pin
  task automatic t_pol();
    int e;
    for (int k = 0; k < NEXT; k++) begin
      e = (k == 0) ? 0 : k + 5;
      wr(A_CTL2, 16'h8000 | (16'h0001 << k));
      wr(A_EN0 + 8'(fw_t[e]), 16'h0001 << fb_t[e]);
      far_u.set_pin(k, 1'b1);
      cycles(4);
      `CHK("rise ignored", 1'b0, irq_req)
      far_u.set_pin(k, 1'b0);
      wait_req(1'b1);
      `CHK("fall vector", 7'(vec_t[e]), irq_vector)
      wait_req(1'b0);
      wr(A_EN0 + 8'(fw_t[e]), 16'h0000);
    end
  endtask

  // simultaneous sources: higher field wins, tie goes to lower vector
  task automatic t_prio();
    far_u.ack_en = 1'b0;
    wr(A_CTL2, 16'h8000);
    wr(A_EN0, 16'h0003);
    for (int r = 0; r < 2; r++) begin
      wr(A_PRIO0, r ? 16'h0055 : 16'h0053);
      fork
        far_u.set_pin(0, 1'b1);
        far_u.pulse_evt(0);
      join
      wait_req(1'b1);
      `CHK("winner", r ? 7'h08 : 7'h09, irq_vector)
      `CHK("winner level", 3'h5, irq_level)
      rd(A_ACTIVE, rv);
      `CHK("active", r ? 16'hd008 : 16'hd009, rv)
      wr(A_FLAG0, 16'h0000);
      wait_req(1'b0);
      far_u.set_pin(0, 1'b0);
    end
    wr(A_EN0, 16'h0000);
    far_u.ack_en = 1'b1;
  endtask

  // global enable gates requests, not traps; event status and mask
  task automatic t_gie();
    wr(A_EVT_STS, 16'h0003);
    wr(A_PRIO0, 16'h0007);
    wr(A_CTL2, 16'h0000);
    wr(A_EN0, 16'h0001);
    far_u.set_pin(0, 1'b1);
    cycles(4);
    `CHK("gated", 1'b0, irq_req)
    wr(A_CTL2, 16'h2000);
    cycles(2);
    `CHK("trap gie off", 1'b1, soft_trap)
    rd(A_EVT_STS, rv);
    `CHK("evt status", 16'h0001, rv)
    `CHK("int masked", 1'b0, int_out)
    wr(A_EVT_MASK, 16'h0001);
    cycles(2);
    `CHK("int unmasked", 1'b1, int_out)
    wr(A_EVT_STS, 16'h0001);
    cycles(2);
    `CHK("int cleared", 1'b0, int_out)
    rd(A_EVT_STS, rv);
    `CHK("evt cleared", 16'h0000, rv)
    wr(A_EVT_MASK, 16'h0002);
    wr(A_CTL2, 16'h8000);
    wait_req(1'b1);
    `CHK("ungated", 7'h08, irq_vector)
    `CHK("int request", 1'b1, int_out)
    `CHK("trap off", 1'b0, soft_trap)
    wait_req(1'b0);
    far_u.set_pin(0, 1'b0);
    wr(A_EVT_STS, 16'hffff);
    wr(A_EVT_MASK, 16'h0000);
  endtask

  // alternate table shifts the address, then a mid-run reset
  task automatic t_alt_reset();
    wr(A_CTL2, 16'h8100);
    far_u.set_pin(0, 1'b1);
    wait_req(1'b1);
    `CHK("alt address", 24'h000014 + ALT, irq_addr)
    wait_req(1'b0);
    far_u.set_pin(0, 1'b0);
    wr(A_CTL2, 16'ha100);
    do_reset();
    `CHK("trap after reset", 1'b0, soft_trap)
    rd(A_CTL2, rv);
    `CHK("ctl2 after reset", CTL2_RST, rv)
  endtask

  // main sequence
  initial begin
    fails  = 0;
    checks = 0;
    arst_n = 1'b0;
    addr   = '0;
    wdata  = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    do_reset();
    t_regs();
    t_map();
    t_pol();
    t_prio();
    t_gie();
    t_alt_reset();
    end_sim();
  end
endmodule
